// ---- core/dbw_pkg.sv ----
// Package: register map, codes, timing and carrier types of the dump box warning block
package dbw_pkg;
	localparam int          ADDR_W          = 8;
	// Register byte offsets
	localparam logic [7:0]  POLARITY_OFF    = 8'h00;
	localparam logic [7:0]  ALARM_SEL_OFF   = 8'h04;
	localparam logic [7:0]  STATUS_OFF      = 8'h08;
	localparam logic [7:0]  IRQ_STAT_OFF    = 8'h0C;
	localparam logic [7:0]  IRQ_MASK_OFF    = 8'h10;
	// Field positions
	localparam int          POL_BODY_LSB    = 0;
	localparam int          POL_GATE_LSB    = 2;
	localparam int          ALM_BODY_MOV    = 0;
	localparam int          ALM_GATE_MOV    = 2;
	localparam int          ALM_BODY_PARK   = 4;
	localparam int          ALM_GATE_PARK   = 6;
	localparam int          IRQ_BITS        = 4;
	// Reset values
	localparam logic [7:0]  POLARITY_RST    = 8'h0F;
	localparam logic [7:0]  ALARM_SEL_RST   = 8'h05;
	localparam logic [3:0]  IRQ_MASK_RST    = 4'h0;
	// Input polarity codes
	localparam logic [1:0]  POL_OPEN        = 2'h0;
	localparam logic [1:0]  POL_GROUND      = 2'h1;
	localparam logic [1:0]  POL_NONE        = 2'h2;
	localparam logic [1:0]  POL_BATTERY     = 2'h3;
	// Alarm type codes
	localparam logic [1:0]  ALARM_OFF       = 2'h0;
	localparam logic [1:0]  ALARM_FAST5     = 2'h1;
	localparam logic [1:0]  ALARM_SLOW3     = 2'h2;
	localparam logic [1:0]  ALARM_CONT      = 2'h3;
	localparam logic [2:0]  FAST_BEEPS      = 3'h5;
	localparam logic [2:0]  SLOW_BEEPS      = 3'h3;
	// AXI responses and speed limit
	localparam logic [1:0]  RESP_OKAY       = 2'h0;
	localparam logic [1:0]  RESP_SLVERR     = 2'h2;
	localparam logic [7:0]  SPEED_LIMIT_MPH = 8'h0A;
	// Timing
	localparam int          CLK_KHZ         = 25000;
	localparam int          FLASH_HALF_MS   = 300;
	localparam int          FAST_BEEP_MS    = 100;
	localparam int          SLOW_BEEP_MS    = 400;
	localparam logic [23:0] FLASH_HALF_CYC  = 24'(FLASH_HALF_MS * CLK_KHZ);
	localparam logic [23:0] FAST_BEEP_CYC   = 24'(FAST_BEEP_MS * CLK_KHZ);
	localparam logic [23:0] SLOW_BEEP_CYC   = 24'(SLOW_BEEP_MS * CLK_KHZ);

	typedef struct packed {
		logic grounded;
		logic atBattery;
	} dbw_switch_t;

	typedef struct packed {
		logic       ignitionRun;
		logic       parkBrakeSet;
		logic [7:0] speedMph;
	} dbw_vehicle_t;

	typedef enum logic [1:0] {
		BEEP_IDLE = 2'b00,
		BEEP_ON   = 2'b01,
		BEEP_GAP  = 2'b10,
		BEEP_DONE = 2'b11
	} dbw_beep_state_t;
endpackage : dbw_pkg

// ---- core/dbw_beep_gen.sv ----
// Module: one audible pattern sequencer, off, five fast, three slow or continuous
`timescale 1ns/1ps
module dbw_beep_gen #(
	parameter logic [23:0] FAST_CYC = dbw_pkg::FAST_BEEP_CYC,
	parameter logic [23:0] SLOW_CYC = dbw_pkg::SLOW_BEEP_CYC
) (
	input  wire logic       sys_clk, // System clock
	input  wire logic       nrst,    // Async reset, active low
	input  wire logic       en,      // Warning condition present
	input  wire logic [1:0] code,    // Selected alarm type
	output logic            beep     // Sounder drive
);
	dbw_pkg::dbw_beep_state_t state_q, state_d;
	logic [23:0]              cnt_q, cnt_d;
	logic [2:0]               left_q, left_d;
	logic [1:0]               codeLast_q;
	logic                     enLast_q;
	logic                     beep_q, beep_d;
	logic [23:0]              len;
	logic                     restart;
	logic [2:0]               rises_q;

	assign len     = (code == dbw_pkg::ALARM_SLOW3) ? SLOW_CYC : FAST_CYC;
	// New condition or new type replays the pattern from its start
	assign restart = en && (!enLast_q || code != codeLast_q);

	always_comb begin
		state_d = state_q;
		cnt_d   = cnt_q;
		left_d  = left_q;
		if (!en || code == dbw_pkg::ALARM_OFF) begin
			state_d = dbw_pkg::BEEP_IDLE;
			cnt_d   = 24'h000000;
		end else if (restart || state_q == dbw_pkg::BEEP_IDLE) begin
			state_d = dbw_pkg::BEEP_ON;
			cnt_d   = 24'h000000;
			left_d  = (code == dbw_pkg::ALARM_FAST5) ? dbw_pkg::FAST_BEEPS : dbw_pkg::SLOW_BEEPS;
		end else if (state_q == dbw_pkg::BEEP_DONE) begin
			cnt_d = 24'h000000;
		end else if (cnt_q == len - 24'h000001) begin
			cnt_d = 24'h000000;
			case (state_q)
				dbw_pkg::BEEP_ON: begin
					state_d = dbw_pkg::BEEP_GAP;
					left_d  = left_q - 3'h1;
				end
				dbw_pkg::BEEP_GAP: begin
					state_d = (code == dbw_pkg::ALARM_CONT || left_q != 3'h0) ?
						dbw_pkg::BEEP_ON : dbw_pkg::BEEP_DONE;
				end
				default: begin
					state_d = dbw_pkg::BEEP_IDLE;
				end
			endcase
		end else begin
			cnt_d = cnt_q + 24'h000001;
		end
		beep_d = (state_d == dbw_pkg::BEEP_ON);
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			state_q    <= dbw_pkg::BEEP_IDLE;
			cnt_q      <= 24'h000000;
			left_q     <= 3'h0;
			codeLast_q <= 2'h0;
			enLast_q   <= 1'b0;
			beep_q     <= 1'b0;
		end else begin
			state_q    <= state_d;
			cnt_q      <= cnt_d;
			left_q     <= left_d;
			codeLast_q <= code;
			enLast_q   <= en;
			beep_q     <= beep_d;
		end
	end

	assign beep = beep_q;

	// Helper: beep starts since the last restart
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			rises_q <= 3'h0;
		end else if (restart) begin
			// First beep of a new pattern counts too
			rises_q <= {2'h0, beep_d};
		end else if (!en) begin
			// Code may change silently while idle, so forget old counts
			rises_q <= 3'h0;
		end else if (beep_d && !beep_q && rises_q != 3'h7) begin
			rises_q <= rises_q + 3'h1;
		end
	end

	beep_silent_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		(!en || code == dbw_pkg::ALARM_OFF) |=> !beep)
		else $error("beep sounded while off");
	fast_count_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		(code == dbw_pkg::ALARM_FAST5 && !restart) |-> rises_q <= 3'h5)
		else $error("more than five fast beeps");
	slow_count_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		(code == dbw_pkg::ALARM_SLOW3 && !restart) |-> rises_q <= 3'h3)
		else $error("more than three slow beeps");
endmodule : dbw_beep_gen

// ---- core/dbw_warning_top.sv ----
// Module: dump box warning logic with AXI4-Lite configuration and interrupt
// Overview of operation
// - Parked and slow: steady lamp, stationary alarm
// - Released brake or fast: flashing lamp, moving alarm
// - Inactive input keeps its lamp dark
// - Everything silent unless ignition in run
// - Per-input polarity: open, ground, none, battery
// - Four alarm selects: off, five, three, continuous
// - Moving alarm selects reset to five fast
// - Stationary alarm selects reset to off
`timescale 1ns/1ps
module dbw_warning_top #(
	parameter logic [23:0] FLASH_HALF_CYC = dbw_pkg::FLASH_HALF_CYC,
	parameter logic [23:0] FAST_BEEP_CYC  = dbw_pkg::FAST_BEEP_CYC,
	parameter logic [23:0] SLOW_BEEP_CYC  = dbw_pkg::SLOW_BEEP_CYC
) (
	input  wire logic                        sys_clk,            // System clock
	input  wire logic                        nrst,               // Async reset, key-off
	input  wire logic [dbw_pkg::ADDR_W-1:0]  awaddr,             // Write address
	input  wire logic                        awvalid,            // Write address valid
	output logic                             awready,            // Write address ready
	input  wire logic [31:0]                 wdata,              // Write data
	input  wire logic [3:0]                  wstrb,              // Write strobes
	input  wire logic                        wvalid,             // Write data valid
	output logic                             wready,             // Write data ready
	output logic [1:0]                       bresp,              // Write response
	output logic                             bvalid,             // Write response valid
	input  wire logic                        bready,             // Write response ready
	input  wire logic [dbw_pkg::ADDR_W-1:0]  araddr,             // Read address
	input  wire logic                        arvalid,            // Read address valid
	output logic                             arready,            // Read address ready
	output logic [31:0]                      rdata,              // Read data
	output logic [1:0]                       rresp,              // Read response
	output logic                             rvalid,             // Read data valid
	input  wire logic                        rready,             // Read data ready
	input  wire dbw_pkg::dbw_switch_t        bodyRaisedSwitchIn, // Body switch level
	input  wire dbw_pkg::dbw_switch_t        gateOpenSwitchIn,   // Gate switch level
	input  wire dbw_pkg::dbw_vehicle_t       vehicle,            // Ignition, brake, speed
	output logic                             bodyRaisedLamp,     // Body raised indicator
	output logic                             gateOpenLamp,       // Gate open indicator
	output logic                             alarmOut,           // Audible alarm drive
	output logic                             irq                 // Interrupt, active high
);
	logic [7:0]          polarity_q, polarity_d;
	logic [7:0]          alarmSel_q, alarmSel_d;
	logic [3:0]          irqStat_q, irqStat_d;
	logic [3:0]          irqMask_q, irqMask_d;
	logic                awHave_q, awHave_d;
	logic [7:0]          awAddr_q, awAddr_d;
	logic                wHave_q, wHave_d;
	logic [7:0]          wByte_q, wByte_d;
	logic                wLane_q, wLane_d;
	logic                bValid_q, bValid_d;
	logic [1:0]          bResp_q, bResp_d;
	logic                rValid_q, rValid_d;
	logic [31:0]         rData_q, rData_d;
	logic [1:0]          rResp_q, rResp_d;
	logic                awReady_q, wReady_q, arReady_q;
	logic [1:0]          warnPrev_q, movePrev_q;
	logic [23:0]         flashCnt_q, flashCnt_d;
	logic                flashPhase_q, flashPhase_d;
	logic [1:0]          lamp_q, lamp_d;
	logic                alarm_q;
	logic                irq_q;
	logic                almWritten_q;
	logic                moving;
	logic [1:0]          chAct, chWarn, chMove, chBeep;
	logic [3:0]          events;
	logic                awTake, wTake, arTake, doWrite;
	dbw_pkg::dbw_switch_t sw [2];
	logic [1:0]          polSel [2];
	logic [1:0]          movSel [2];
	logic [1:0]          parkSel [2];

	assign moving = !vehicle.parkBrakeSet || (vehicle.speedMph > dbw_pkg::SPEED_LIMIT_MPH);

	assign sw[0]      = bodyRaisedSwitchIn;
	assign sw[1]      = gateOpenSwitchIn;
	assign polSel[0]  = polarity_q[dbw_pkg::POL_BODY_LSB +: 2];
	assign polSel[1]  = polarity_q[dbw_pkg::POL_GATE_LSB +: 2];
	assign movSel[0]  = alarmSel_q[dbw_pkg::ALM_BODY_MOV +: 2];
	assign movSel[1]  = alarmSel_q[dbw_pkg::ALM_GATE_MOV +: 2];
	assign parkSel[0] = alarmSel_q[dbw_pkg::ALM_BODY_PARK +: 2];
	assign parkSel[1] = alarmSel_q[dbw_pkg::ALM_GATE_PARK +: 2];

	genvar ch;
	generate
		for (ch = 0; ch < 2; ch++) begin : g_chan
			always_comb begin
				case (polSel[ch])
					dbw_pkg::POL_OPEN:    chAct[ch] = !sw[ch].grounded && !sw[ch].atBattery;
					dbw_pkg::POL_GROUND:  chAct[ch] = sw[ch].grounded;
					dbw_pkg::POL_BATTERY: chAct[ch] = sw[ch].atBattery;
					default:              chAct[ch] = 1'b0;
				endcase
			end
			assign chWarn[ch] = vehicle.ignitionRun && chAct[ch];
			assign chMove[ch] = chWarn[ch] && moving;
			assign lamp_d[ch] = chWarn[ch] && (!moving || flashPhase_q);
			dbw_beep_gen #(
				.FAST_CYC (FAST_BEEP_CYC),
				.SLOW_CYC (SLOW_BEEP_CYC)
			) u_beep (
				.sys_clk (sys_clk),
				.nrst    (nrst),
				.en      (chWarn[ch]),
				.code    (moving ? movSel[ch] : parkSel[ch]),
				.beep    (chBeep[ch])
			);
		end
	endgenerate

	// Flash phase restarts lit so a new warning shows at once
	always_comb begin
		flashCnt_d   = flashCnt_q;
		flashPhase_d = flashPhase_q;
		if (!(|chMove)) begin
			flashCnt_d   = 24'h000000;
			flashPhase_d = 1'b1;
		end else if (flashCnt_q == FLASH_HALF_CYC - 24'h000001) begin
			flashCnt_d   = 24'h000000;
			flashPhase_d = !flashPhase_q;
		end else begin
			flashCnt_d = flashCnt_q + 24'h000001;
		end
	end

	assign events = {chMove & ~movePrev_q, chWarn & ~warnPrev_q};
	assign awTake = awvalid && awReady_q;
	assign wTake  = wvalid && wReady_q;
	assign arTake = arvalid && arReady_q;

	// Register file and AXI4-Lite slave, one write and one read in flight
	always_comb begin
		polarity_d = polarity_q;
		alarmSel_d = alarmSel_q;
		irqMask_d  = irqMask_q;
		irqStat_d  = irqStat_q;
		awHave_d   = awHave_q;
		awAddr_d   = awAddr_q;
		wHave_d    = wHave_q;
		wByte_d    = wByte_q;
		wLane_d    = wLane_q;
		bValid_d   = bValid_q;
		bResp_d    = bResp_q;
		rValid_d   = rValid_q;
		rData_d    = rData_q;
		rResp_d    = rResp_q;
		if (awTake) begin
			awHave_d = 1'b1;
			awAddr_d = awaddr;
		end
		if (wTake) begin
			wHave_d = 1'b1;
			wByte_d = wdata[7:0];
			wLane_d = wstrb[0];
		end
		if (bValid_q && bready) begin
			bValid_d = 1'b0;
		end
		doWrite = awHave_d && wHave_d && !bValid_q;
		if (doWrite) begin
			awHave_d = 1'b0;
			wHave_d  = 1'b0;
			bValid_d = 1'b1;
			bResp_d  = dbw_pkg::RESP_OKAY;
			if (awAddr_d == dbw_pkg::POLARITY_OFF) begin
				if (wLane_d) polarity_d = wByte_d;
			end else if (awAddr_d == dbw_pkg::ALARM_SEL_OFF) begin
				if (wLane_d) alarmSel_d = wByte_d;
			end else if (awAddr_d == dbw_pkg::IRQ_MASK_OFF) begin
				if (wLane_d) irqMask_d = wByte_d[3:0];
			end else if (awAddr_d == dbw_pkg::STATUS_OFF || awAddr_d == dbw_pkg::IRQ_STAT_OFF) begin
				bResp_d = dbw_pkg::RESP_OKAY;
			end else begin
				bResp_d = dbw_pkg::RESP_SLVERR;
			end
		end
		if (rValid_q && rready) begin
			rValid_d = 1'b0;
		end
		if (arTake) begin
			rValid_d = 1'b1;
			rResp_d  = dbw_pkg::RESP_OKAY;
			if (araddr == dbw_pkg::POLARITY_OFF) begin
				rData_d = {24'h000000, polarity_q};
			end else if (araddr == dbw_pkg::ALARM_SEL_OFF) begin
				rData_d = {24'h000000, alarmSel_q};
			end else if (araddr == dbw_pkg::STATUS_OFF) begin
				rData_d = {25'h0000000, alarm_q, lamp_q, vehicle.ignitionRun, moving, chAct};
			end else if (araddr == dbw_pkg::IRQ_STAT_OFF) begin
				rData_d   = {28'h0000000, irqStat_q};
				irqStat_d = 4'h0;
			end else if (araddr == dbw_pkg::IRQ_MASK_OFF) begin
				rData_d = {28'h0000000, irqMask_q};
			end else begin
				rData_d = 32'h00000000;
				rResp_d = dbw_pkg::RESP_SLVERR;
			end
		end
		// New events win over a read clear in the same cycle
		irqStat_d = irqStat_d | events;
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			// moving selects, stationary selects, polarity defaults
			polarity_q   <= dbw_pkg::POLARITY_RST;
			alarmSel_q   <= dbw_pkg::ALARM_SEL_RST;
			irqMask_q    <= dbw_pkg::IRQ_MASK_RST;
			irqStat_q    <= 4'h0;
			awHave_q     <= 1'b0;
			awAddr_q     <= 8'h00;
			wHave_q      <= 1'b0;
			wByte_q      <= 8'h00;
			wLane_q      <= 1'b0;
			bValid_q     <= 1'b0;
			bResp_q      <= 2'h0;
			rValid_q     <= 1'b0;
			rData_q      <= 32'h00000000;
			rResp_q      <= 2'h0;
			awReady_q    <= 1'b0;
			wReady_q     <= 1'b0;
			arReady_q    <= 1'b0;
			warnPrev_q   <= 2'h0;
			movePrev_q   <= 2'h0;
			flashCnt_q   <= 24'h000000;
			flashPhase_q <= 1'b1;
			lamp_q       <= 2'h0;
			alarm_q      <= 1'b0;
			irq_q        <= 1'b0;
		end else begin
			polarity_q   <= polarity_d;
			alarmSel_q   <= alarmSel_d;
			irqMask_q    <= irqMask_d;
			irqStat_q    <= irqStat_d;
			awHave_q     <= awHave_d;
			awAddr_q     <= awAddr_d;
			wHave_q      <= wHave_d;
			wByte_q      <= wByte_d;
			wLane_q      <= wLane_d;
			bValid_q     <= bValid_d;
			bResp_q      <= bResp_d;
			rValid_q     <= rValid_d;
			rData_q      <= rData_d;
			rResp_q      <= rResp_d;
			awReady_q    <= !awHave_d && !bValid_d;
			wReady_q     <= !wHave_d && !bValid_d;
			arReady_q    <= !rValid_d;
			warnPrev_q   <= chWarn;
			movePrev_q   <= chMove;
			flashCnt_q   <= flashCnt_d;
			flashPhase_q <= flashPhase_d;
			lamp_q       <= lamp_d;
			alarm_q      <= |chBeep;
			irq_q        <= |(irqStat_d & irqMask_d);
		end
	end

	assign awready        = awReady_q;
	assign wready         = wReady_q;
	assign bvalid         = bValid_q;
	assign bresp          = bResp_q;
	assign arready        = arReady_q;
	assign rvalid         = rValid_q;
	assign rdata          = rData_q;
	assign rresp          = rResp_q;
	assign bodyRaisedLamp = lamp_q[0];
	assign gateOpenLamp   = lamp_q[1];
	assign alarmOut       = alarm_q;
	assign irq            = irq_q;

	// Helper: alarm selects untouched since reset
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			almWritten_q <= 1'b0;
		end else if (doWrite && awAddr_d == dbw_pkg::ALARM_SEL_OFF) begin
			almWritten_q <= 1'b1;
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);

	steady_lamp_a: assert property (
		(chWarn[0] && !moving) |=> bodyRaisedLamp)
		else $error("body lamp not steady while parked");
	flash_lamp_a: assert property (
		(chWarn[1] && moving) |=> gateOpenLamp == $past(flashPhase_q))
		else $error("gate lamp not following flash phase");
	lamp_dark_a: assert property (
		(!chAct[0] |=> !bodyRaisedLamp) and (!chAct[1] |=> !gateOpenLamp))
		else $error("lamp lit with inactive input");
	ign_off_a: assert property (
		(!vehicle.ignitionRun ##1 !vehicle.ignitionRun) |=> !alarmOut && !bodyRaisedLamp && !gateOpenLamp)
		else $error("indication while ignition off");
	pol_none_a: assert property (
		((polSel[0] == dbw_pkg::POL_NONE) |=> !bodyRaisedLamp)
		and ((polSel[1] == dbw_pkg::POL_NONE) |=> !gateOpenLamp))
		else $error("lamp lit with polarity none");
	move_reset_a: assert property (
		!almWritten_q |-> (movSel[0] == dbw_pkg::ALARM_FAST5 && movSel[1] == dbw_pkg::ALARM_FAST5))
		else $error("moving alarm select not five fast after reset");
	park_reset_a: assert property (
		!almWritten_q |-> (parkSel[0] == dbw_pkg::ALARM_OFF && parkSel[1] == dbw_pkg::ALARM_OFF))
		else $error("stationary alarm select not off after reset");
	park_quiet_a: assert property (
		(!moving && parkSel[0] == dbw_pkg::ALARM_OFF && parkSel[1] == dbw_pkg::ALARM_OFF) [*3]
		|-> !alarmOut)
		else $error("alarm sounded with stationary selects off");
	irq_level_a: assert property (
		1'b1 |=> irq == |($past(irqStat_d) & $past(irqMask_d)))
		else $error("interrupt level does not follow masked status");
endmodule : dbw_warning_top

// ---- bench/dbw_body_ctrl_model.sv ----
// Behavioural model of the body controller relaying remote switch and vehicle states
`timescale 1ns/1ps
module dbw_body_ctrl_model (
	input  wire logic              sys_clk,   // System clock
	input  wire logic              nrst,      // Key-off reset, active low
	input  wire logic [1:0]        bodyState, // 0 open, 1 grounded, 2 at battery
	input  wire logic [1:0]        gateState, // 0 open, 1 grounded, 2 at battery
	input  wire logic              ignRun,    // Key in run
	input  wire logic              brakeSet,  // Park brake applied
	input  wire logic [7:0]        speed,     // Road speed in mph
	output dbw_pkg::dbw_switch_t   bodySw,    // Relayed body switch level
	output dbw_pkg::dbw_switch_t   gateSw,    // Relayed gate switch level
	output dbw_pkg::dbw_vehicle_t  veh        // Relayed vehicle status
);
	// Relay adds one message delay, as a datalink hop would
	// switch and vehicle state relay
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			bodySw <= '0;
			gateSw <= '0;
			veh    <= '0;
		end else begin
			bodySw <= '{grounded: bodyState == 2'h1, atBattery: bodyState == 2'h2};
			gateSw <= '{grounded: gateState == 2'h1, atBattery: gateState == 2'h2};
			veh    <= '{ignitionRun: ignRun, parkBrakeSet: brakeSet, speedMph: speed};
		end
	end
endmodule : dbw_body_ctrl_model

// ---- bench/testbench.sv ----
// Self-checking bench for the dump box warning block
`timescale 1ns/1ps
module testbench;
	logic        sys_clk = 1'b0;
	logic        nrst    = 1'b0;
	logic [7:0]  awaddr  = 8'h00;
	logic        awvalid = 1'b0;
	logic [31:0] wdata   = 32'h00000000;
	logic [3:0]  wstrb   = 4'h0;
	logic        wvalid  = 1'b0;
	logic        bready  = 1'b0;
	logic [7:0]  araddr  = 8'h00;
	logic        arvalid = 1'b0;
	logic        rready  = 1'b0;
	logic [1:0]  bodySt  = 2'h0;
	logic [1:0]  gateSt  = 2'h0;
	logic        ign     = 1'b0;
	logic        brake   = 1'b0;
	logic [7:0]  speed   = 8'h00;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp, rs;
	logic [31:0] rdata, rd;
	logic        bodyLamp, gateLamp, alarm, irq;
	dbw_pkg::dbw_switch_t  bodySw, gateSw;
	dbw_pkg::dbw_vehicle_t veh;
	int          n_errors     = 0;
	int          total_checks = 0;
	int          cyc          = 0;
	int          c;
	int          expB[4]      = '{0, 5, 3, 1};

	initial forever #20 sys_clk = ~sys_clk;

	dbw_body_ctrl_model partner (.sys_clk(sys_clk), .nrst(nrst), .bodyState(bodySt),
		.gateState(gateSt), .ignRun(ign), .brakeSet(brake), .speed(speed),
		.bodySw(bodySw), .gateSw(gateSw), .veh(veh));

	// Short timings keep the run brief
	dbw_warning_top #(.FLASH_HALF_CYC(24'h000008), .FAST_BEEP_CYC(24'h000004),
		.SLOW_BEEP_CYC(24'h00000C)) uut (.sys_clk(sys_clk), .nrst(nrst),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
		.wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .bodyRaisedSwitchIn(bodySw), .gateOpenSwitchIn(gateSw),
		.vehicle(veh), .bodyRaisedLamp(bodyLamp), .gateOpenLamp(gateLamp),
		.alarmOut(alarm), .irq(irq));

	task print_verdict;
		if (n_errors == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : print_verdict

	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			n_errors++;
			print_verdict();
		end
	end

	task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	task wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge sys_clk);
		awaddr  <= a;
		awvalid <= 1'b1;
		wdata   <= d;
		wstrb   <= 4'hF;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		while (1) begin
			@(posedge sys_clk);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
			if (bvalid === 1'b1) break;
		end
		r = bresp;
		bready <= 1'b0;
	endtask : wr

	task rd_reg(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge sys_clk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		while (1) begin
			@(posedge sys_clk);
			if (arready === 1'b1) arvalid <= 1'b0;
			if (rvalid === 1'b1) break;
		end
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask : rd_reg

	// Drive the far side, then let relay and design latency pass
	task drive(input logic [1:0] b, g, input logic i, k, input logic [7:0] s);
		@(posedge sys_clk);
		bodySt <= b;
		gateSt <= g;
		ign    <= i;
		brake  <= k;
		speed  <= s;
		repeat (4) @(negedge sys_clk);
	endtask : drive

	// Starts from low so a beep already sounding still counts
	task rises(input int n, output int cnt);
		logic p;
		p = 1'b0;
		cnt = 0;
		repeat (n) begin
			@(negedge sys_clk);
			if (alarm === 1'b1 && p !== 1'b1) cnt++;
			p = alarm;
		end
	endtask : rises

	task ones(input int n, output int cnt);
		cnt = 0;
		repeat (n) begin
			@(negedge sys_clk);
			if (bodyLamp === 1'b1) cnt++;
		end
	endtask : ones

	initial begin
		repeat (12) @(posedge sys_clk);
		nrst <= 1'b1;
		rd_reg(dbw_pkg::POLARITY_OFF, rd, rs);
		chk("polarity", 32'h0000000F, rd);
		rd_reg(dbw_pkg::ALARM_SEL_OFF, rd, rs);
		chk("alarmSel", 32'h00000005, rd);
		rd_reg(8'h20, rd, rs);
		chk("unmappedRead", 32'h2, 32'(rs));
		wr(8'h20, 32'h000000FF, rs);
		chk("unmappedWrite", 32'h2, 32'(rs));
		drive(2'h2, 2'h0, 1'b1, 1'b1, 8'h0A);
		ones(20, c);
		chk("steadyLamp", 32'd20, 32'(c));
		chk("gateDark", 32'h0, 32'(gateLamp));
		rises(60, c);
		chk("parkedSilent", 32'h0, 32'(c));
		chk("irqMasked", 32'h0, 32'(irq));
		rd_reg(dbw_pkg::IRQ_STAT_OFF, rd, rs);
		chk("irqStat", 32'h1, rd & 32'h1);
		wr(dbw_pkg::IRQ_MASK_OFF, 32'h1, rs);
		drive(2'h0, 2'h0, 1'b1, 1'b1, 8'h0A);
		chk("bodyDark", 32'h0, 32'(bodyLamp));
		drive(2'h2, 2'h0, 1'b1, 1'b1, 8'h0A);
		chk("irqRaised", 32'h1, 32'(irq));
		rd_reg(dbw_pkg::IRQ_STAT_OFF, rd, rs);
		repeat (2) @(negedge sys_clk);
		chk("irqCleared", 32'h0, 32'(irq));
		for (int k = 0; k < 4; k++) begin
			wr(dbw_pkg::ALARM_SEL_OFF, 32'((k << 4) | 5), rs);
			rises(100, c);
			chk("parkedBeeps", 32'(expB[k]), (k == 3) ? 32'(c > 5) : 32'(c));
		end
		wr(dbw_pkg::ALARM_SEL_OFF, 32'h00000005, rs);
		drive(2'h2, 2'h0, 1'b1, 1'b1, 8'h0B);
		rises(60, c);
		chk("movingBeeps", 32'd5, 32'(c));
		ones(40, c);
		chk("flashSpeed", 32'h1, 32'(c > 0 && c < 40));
		// Gate joins in too, though only the body lamp's flashing is counted
		drive(2'h2, 2'h2, 1'b1, 1'b0, 8'h05);
		ones(40, c);
		chk("flashBrake", 32'h1, 32'(c > 0 && c < 40));
		wr(dbw_pkg::ALARM_SEL_OFF, 32'h00000007, rs);
		drive(2'h2, 2'h0, 1'b0, 1'b0, 8'h05);
		ones(20, c);
		chk("keyOffLamp", 32'h0, 32'(c));
		rises(20, c);
		chk("keyOffAlarm", 32'h0, 32'(c));
		for (int p = 0; p < 4; p++) begin
			wr(dbw_pkg::POLARITY_OFF, 32'((p << 2) | 3), rs);
			for (int e = 0; e < 3; e++) begin
				drive(2'h0, 2'(e), 1'b1, 1'b1, 8'h0A);
				chk("gatePolarity", 32'((p == 0 && e == 0) || (p == 1 && e == 1)
					|| (p == 3 && e == 2)), 32'(gateLamp));
			end
		end
		print_verdict();
	end
endmodule : testbench
